// *** logic/trail_prot_pkg.sv ***
// constants and types for the 1+1 bi-directional higher-order path protection block
// assumes a 250 MHz control clock and a byte-wide connection stream with frame start
package trail_prot_pkg;

	// control clock rate in kHz
	localparam int CLK_KHZ = 250000;
	// hold-off and wait-to-restore step, in ms
	localparam int STEP_MS = 100;
	localparam int STEP_CYCLES_DEF = STEP_MS * CLK_KHZ;
	// longest allowed switch time, in ms
	localparam int SWITCH_MS = 50;
	localparam int SWITCH_CYCLES = SWITCH_MS * CLK_KHZ;
	// wait-to-restore is given in minutes, counted in 100 ms steps
	localparam int WTR_STEPS_PER_MIN = 600;

	// byte index after frame start that carries the switching overhead byte
	localparam logic [11:0] K3_BYTE_POS = 12'h004;
	// identical frames needed before a received switching word is taken
	localparam logic [1:0] APS_PERSIST = 2'h3;

	// indices into the synchronised condition vector
	localparam int IDX_SDW = 0;
	localparam int IDX_SFW = 1;
	localparam int IDX_SDP = 2;
	localparam int IDX_SFP = 3;

	// switching word codes, higher code wins
	typedef enum logic [3:0] {
		REQ_NR = 4'h0, REQ_DNR = 4'h1, REQ_EXER0 = 4'h2, REQ_EXER1 = 4'h3,
		REQ_WTR = 4'h4, REQ_MS0 = 4'h5, REQ_MS1 = 4'h6, REQ_SD = 4'h7,
		REQ_SFW = 4'h8, REQ_FS0 = 4'h9, REQ_FS1 = 4'hA, REQ_SFP = 4'hB,
		REQ_LO = 4'hC
	} req_t;

	typedef enum logic [3:0] {
		CMD_NONE = 4'h0, CMD_LO = 4'h1, CMD_FS0 = 4'h2, CMD_FS1 = 4'h3,
		CMD_MS0 = 4'h4, CMD_MS1 = 4'h5, CMD_EX0 = 4'h6, CMD_EX1 = 4'h7,
		CMD_CLR = 4'h8
	} cmd_t;

	// gray along work -> protection -> wait-to-restore
	typedef enum logic [1:0] {
		ST_WORK = 2'h0, ST_PROT = 2'h1, ST_WTR = 2'h3
	} state_t;

endpackage

// *** logic/trail_prot.sv ***
// 1+1 bi-directional path protection: bridge, selector, switching control,
// protection termination and adaptation with switching word on the protection path.
// assumes all connection streams share link_clk; config and commands are on clk, except fail_report_enable, which is read on link_clk.
`timescale 1ns/1ps

module trail_prot
	import trail_prot_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic revert_select,
	input wire logic [3:0] wait_restore_period,
	input wire logic [6:0] holdoff_period,
	input wire logic [3:0] operator_command,
	input wire logic operator_command_valid,
	input wire logic fail_report_enable,
	input wire logic [7:0] normal_in_data,
	input wire logic normal_in_fs,
	output logic [7:0] working_out_data,
	output logic working_out_fs,
	output logic [7:0] protection_out_data,
	output logic protection_out_fs,
	input wire logic [7:0] working_in_data,
	input wire logic working_in_fs,
	input wire logic trail_fail_indication_w,
	input wire logic trail_degrade_indication_w,
	input wire logic [7:0] protection_in_data,
	input wire logic protection_in_fs,
	input wire logic trail_fail_indication_p,
	input wire logic trail_degrade_indication_p,
	output logic [7:0] normal_out_data,
	output logic normal_out_fs,
	output logic trail_fail_action,
	output logic fail_cause_report,
	output logic protection_selected,
	output logic [3:0] local_request,
	output logic command_rejected
);

	function automatic logic cmd_ok(input cmd_t c, input logic rev);
		case (c)
			CMD_LO, CMD_FS1, CMD_MS1, CMD_CLR: cmd_ok = 1'b1;
			CMD_FS0, CMD_MS0, CMD_EX0, CMD_EX1: cmd_ok = !rev;
			default: cmd_ok = 1'b0;
		endcase
	endfunction

	function automatic logic sel_prot(input req_t r);
		case (r)
			REQ_DNR, REQ_WTR, REQ_MS1, REQ_SD, REQ_SFW, REQ_FS1: sel_prot = 1'b1;
			default: sel_prot = 1'b0;
		endcase
	endfunction

	function automatic logic [11:0] byte_idx(input logic fs, input logic [11:0] cnt);
		byte_idx = fs ? 12'h000 : cnt;
	endfunction

	// control domain state
	logic [3:0] fs1_q, fs1_d, fs2_q, fs2_d, acc_q, acc_d, new_bits;
	logic [24:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	logic [6:0] ho_cnt_q, ho_cnt_d;
	// 15 minutes of 100 ms steps needs 14 bits
	logic [13:0] wtr_cnt_q, wtr_cnt_d, wtr_target;
	cmd_t ext_q, ext_d, cmd_in;
	logic rej_q, rej_d;
	state_t state_q, state_d;
	logic wtr_ok_q, wtr_ok_d, sel_q, sel_d;
	req_t cond, base, req_local, remote, winner;
	logic [3:0] tx_word_q, tx_word_d, rx_word_q, rx_word_d;
	logic tx_tog_q, tx_tog_d, ack1_q, ack1_d, ack2_q, ack2_d;
	logic rs1_q, rs1_d, rs2_q, rs2_d, rs3_q, rs3_d;

	// link domain state
	logic tl1_q, tl1_d, tl2_q, tl2_d, tl3_q, tl3_d, sl1_q, sl1_d, sl2_q, sl2_d;
	logic [3:0] tx_link_q, tx_link_d;
	logic [11:0] txpos_q, txpos_d, rxpos_q, rxpos_d, tx_idx, rx_idx;
	logic [7:0] wdata_q, wdata_d, pdata_q, pdata_d, ndata_q, ndata_d;
	logic wfs_q, wfs_d, pfs_q, pfs_d, nfs_q, nfs_d, tfa_q, tfa_d, fcr_q, fcr_d;
	logic [3:0] rx_cand_q, rx_cand_d, rx_acc_q, rx_acc_d, nib;
	logic [1:0] rx_cnt_q, rx_cnt_d;
	logic rx_tog_q, rx_tog_d;
	logic server_fail_w, server_fail_p, server_degrade_w, server_degrade_p;

	assign server_fail_w = trail_fail_indication_w;
	assign server_fail_p = trail_fail_indication_p;
	assign server_degrade_w = trail_degrade_indication_w;
	assign server_degrade_p = trail_degrade_indication_p;

	always_comb
	begin
		fs1_d = {server_fail_p, server_degrade_p, server_fail_w, server_degrade_w};
		fs2_d = fs1_q;
		tick = (tick_cnt_q == 25'(STEP_CYCLES - 1));
		tick_cnt_d = tick ? 25'h0000000 : tick_cnt_q + 25'h0000001;
		// only rising conditions wait; clearing is immediate
		new_bits = fs2_q & ~acc_q;
		if (new_bits == 4'h0)
			ho_cnt_d = 7'h00;
		else if (tick && ho_cnt_q != 7'h7F)
			ho_cnt_d = ho_cnt_q + 7'h01;
		else
			ho_cnt_d = ho_cnt_q;
		acc_d = fs2_q & acc_q;
		if (holdoff_period == 7'h00 || ho_cnt_q >= holdoff_period)
			acc_d = acc_d | new_bits;
		cmd_in = cmd_t'(operator_command);
		ext_d = ext_q;
		rej_d = 1'b0;
		if (operator_command_valid)
		begin
			if (cmd_ok(cmd_in, revert_select))
				ext_d = (cmd_in == CMD_CLR) ? CMD_NONE : cmd_in;
			else
				rej_d = 1'b1;
		end
		cond = REQ_NR;
		if (ext_q == CMD_LO)
			cond = REQ_LO;
		else if (acc_q[IDX_SFP])
			cond = REQ_SFP;
		else if (ext_q == CMD_FS1)
			cond = REQ_FS1;
		else if (ext_q == CMD_FS0)
			cond = REQ_FS0;
		else if (acc_q[IDX_SFW])
			cond = REQ_SFW;
		else if (acc_q[IDX_SDW] && !acc_q[IDX_SDP])
			cond = REQ_SD;
		else if (ext_q == CMD_MS1)
			cond = REQ_MS1;
		else if (ext_q == CMD_MS0)
			cond = REQ_MS0;
		else if (ext_q == CMD_EX1 && state_q != ST_WTR)
			cond = REQ_EXER1;
		else if (ext_q == CMD_EX0 && state_q != ST_WTR)
			cond = REQ_EXER0;
		// mode only matters once a switch exists, so idle traffic is untouched
		if (state_q == ST_WTR)
			base = REQ_WTR;
		else if (state_q == ST_PROT && !revert_select)
			base = REQ_DNR;
		else
			base = REQ_NR;
		req_local = (cond != REQ_NR) ? cond : base;
		// far end word ignored while the protection path itself has failed
		if (acc_q[IDX_SFP] || rx_word_q > 4'(REQ_LO))
			remote = REQ_NR;
		else
			remote = req_t'(rx_word_q);
		winner = (remote > req_local) ? remote : req_local;
		wtr_target = 14'(wait_restore_period * WTR_STEPS_PER_MIN);
		state_d = state_q;
		case (state_q)
			ST_WORK:
			begin
				if (sel_prot(winner))
					state_d = ST_PROT;
			end
			ST_PROT:
			begin
				if (revert_select && wtr_ok_q && cond == REQ_NR && remote <= REQ_WTR)
					state_d = ST_WTR;
				// exercise only tests signalling, it never moves the selector
				else if (!sel_prot(winner) && winner != REQ_EXER0 && winner != REQ_EXER1)
					state_d = ST_WORK;
			end
			ST_WTR:
			begin
				if (cond != REQ_NR || remote > REQ_WTR)
					state_d = sel_prot(winner) ? ST_PROT : ST_WORK;
				else if (!revert_select)
					state_d = ST_PROT;
				else if (wtr_cnt_q >= wtr_target)
					state_d = ST_WORK;
			end
			default: state_d = ST_WORK;
		endcase
		if (state_q != ST_WTR)
			wtr_cnt_d = 14'h0000;
		else if (tick && wtr_cnt_q != 14'h3FFF)
			wtr_cnt_d = wtr_cnt_q + 14'h0001;
		else
			wtr_cnt_d = wtr_cnt_q;
		if (winner == REQ_SFW || winner == REQ_SD)
			wtr_ok_d = 1'b1;
		else
			wtr_ok_d = (state_d == ST_WORK) ? 1'b0 : wtr_ok_q;
		sel_d = (state_d != ST_WORK);
		// toggle handshake; the word holds until the link side echoes the toggle
		tx_word_d = tx_word_q;
		tx_tog_d = tx_tog_q;
		if (ack2_q == tx_tog_q && 4'(req_local) != tx_word_q)
		begin
			tx_word_d = 4'(req_local);
			tx_tog_d = !tx_tog_q;
		end
		ack1_d = tl3_q;
		ack2_d = ack1_q;
		rs1_d = rx_tog_q;
		rs2_d = rs1_q;
		rs3_d = rs2_q;
		// rx_acc_q holds for whole frames after its toggle, so it is stable here
		rx_word_d = (rs2_q ^ rs3_q) ? rx_acc_q : rx_word_q;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fs1_q <= 4'h0;
			fs2_q <= 4'h0;
			acc_q <= 4'h0;
			tick_cnt_q <= 25'h0000000;
			ho_cnt_q <= 7'h00;
			wtr_cnt_q <= 14'h0000;
			ext_q <= CMD_NONE;
			rej_q <= 1'b0;
			state_q <= ST_WORK;
			wtr_ok_q <= 1'b0;
			sel_q <= 1'b0;
			tx_word_q <= 4'h0;
			tx_tog_q <= 1'b0;
			ack1_q <= 1'b0;
			ack2_q <= 1'b0;
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
			rs3_q <= 1'b0;
			rx_word_q <= 4'h0;
		end
		else
		begin
			fs1_q <= fs1_d;
			fs2_q <= fs2_d;
			acc_q <= acc_d;
			tick_cnt_q <= tick_cnt_d;
			ho_cnt_q <= ho_cnt_d;
			wtr_cnt_q <= wtr_cnt_d;
			ext_q <= ext_d;
			rej_q <= rej_d;
			state_q <= state_d;
			wtr_ok_q <= wtr_ok_d;
			sel_q <= sel_d;
			tx_word_q <= tx_word_d;
			tx_tog_q <= tx_tog_d;
			ack1_q <= ack1_d;
			ack2_q <= ack2_d;
			rs1_q <= rs1_d;
			rs2_q <= rs2_d;
			rs3_q <= rs3_d;
			rx_word_q <= rx_word_d;
		end
	end

	assign protection_selected = sel_q;
	assign local_request = tx_word_q;
	assign command_rejected = rej_q;

	always_comb
	begin
		tl1_d = tx_tog_q;
		tl2_d = tl1_q;
		tl3_d = tl2_q;
		tx_link_d = (tl2_q ^ tl3_q) ? tx_word_q : tx_link_q;
		sl1_d = sel_q;
		sl2_d = sl1_q;
		tx_idx = byte_idx(normal_in_fs, txpos_q);
		txpos_d = tx_idx + 12'h001;
		wdata_d = normal_in_data;
		wfs_d = normal_in_fs;
		pfs_d = normal_in_fs;
		if (tx_idx == K3_BYTE_POS)
			pdata_d = {tx_link_q, normal_in_data[3:0]};
		else
			pdata_d = normal_in_data;
		rx_idx = byte_idx(protection_in_fs, rxpos_q);
		rxpos_d = rx_idx + 12'h001;
		nib = protection_in_data[7:4];
		rx_cand_d = rx_cand_q;
		rx_cnt_d = rx_cnt_q;
		rx_acc_d = rx_acc_q;
		rx_tog_d = rx_tog_q;
		// a failed protection path carries nothing worth filtering
		if (rx_idx == K3_BYTE_POS && !server_fail_p)
		begin
			if (nib != rx_cand_q)
			begin
				rx_cand_d = nib;
				rx_cnt_d = 2'h1;
			end
			else if (rx_cnt_q != APS_PERSIST)
				rx_cnt_d = rx_cnt_q + 2'h1;
			if (rx_cnt_d == APS_PERSIST && rx_cand_d != rx_acc_q)
			begin
				rx_acc_d = rx_cand_d;
				rx_tog_d = !rx_tog_q;
			end
		end
		ndata_d = sl2_q ? protection_in_data : working_in_data;
		nfs_d = sl2_q ? protection_in_fs : working_in_fs;
		tfa_d = sl2_q ? server_fail_p : server_fail_w;
		fcr_d = tfa_d && fail_report_enable;
	end

	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tl1_q <= 1'b0;
			tl2_q <= 1'b0;
			tl3_q <= 1'b0;
			tx_link_q <= 4'h0;
			sl1_q <= 1'b0;
			sl2_q <= 1'b0;
			txpos_q <= 12'h000;
			rxpos_q <= 12'h000;
			wdata_q <= 8'h00;
			pdata_q <= 8'h00;
			ndata_q <= 8'h00;
			wfs_q <= 1'b0;
			pfs_q <= 1'b0;
			nfs_q <= 1'b0;
			tfa_q <= 1'b0;
			fcr_q <= 1'b0;
			rx_cand_q <= 4'h0;
			rx_cnt_q <= 2'h0;
			rx_acc_q <= 4'h0;
			rx_tog_q <= 1'b0;
		end
		else
		begin
			tl1_q <= tl1_d;
			tl2_q <= tl2_d;
			tl3_q <= tl3_d;
			tx_link_q <= tx_link_d;
			sl1_q <= sl1_d;
			sl2_q <= sl2_d;
			txpos_q <= txpos_d;
			rxpos_q <= rxpos_d;
			wdata_q <= wdata_d;
			pdata_q <= pdata_d;
			ndata_q <= ndata_d;
			wfs_q <= wfs_d;
			pfs_q <= pfs_d;
			nfs_q <= nfs_d;
			tfa_q <= tfa_d;
			fcr_q <= fcr_d;
			rx_cand_q <= rx_cand_d;
			rx_cnt_q <= rx_cnt_d;
			rx_acc_q <= rx_acc_d;
			rx_tog_q <= rx_tog_d;
		end
	end

	assign working_out_data = wdata_q;
	assign working_out_fs = wfs_q;
	assign protection_out_data = pdata_q;
	assign protection_out_fs = pfs_q;
	assign normal_out_data = ndata_q;
	assign normal_out_fs = nfs_q;
	assign trail_fail_action = tfa_q;
	assign fail_cause_report = fcr_q;

	a_bridge_working: assert property (@(posedge link_clk) disable iff (!reset_n)
		1'b1 |=> working_out_data == $past(normal_in_data) && working_out_fs == $past(normal_in_fs))
		else $error("working output is not the bridged normal input");

	a_bridge_protect: assert property (@(posedge link_clk) disable iff (!reset_n)
		tx_idx != K3_BYTE_POS |=> protection_out_data == $past(normal_in_data))
		else $error("protection output altered outside the overhead byte");

	a_word_insert: assert property (@(posedge link_clk) disable iff (!reset_n)
		tx_idx == K3_BYTE_POS |=> protection_out_data[7:4] == $past(tx_link_q)
			&& protection_out_data[3:0] == $past(normal_in_data[3:0]))
		else $error("switching word not inserted in overhead bits");

	a_normal_select: assert property (@(posedge link_clk) disable iff (!reset_n)
		1'b1 |=> normal_out_data == ($past(sl2_q) ? $past(protection_in_data)
			: $past(working_in_data)))
		else $error("normal output does not follow the selected path");

	a_fail_report: assert property (@(posedge link_clk) disable iff (!reset_n)
		1'b1 |=> fail_cause_report == (trail_fail_action && $past(fail_report_enable)))
		else $error("fail cause report not gated by its enable");

	a_lockout_work: assert property (@(posedge clk) disable iff (!reset_n)
		ext_q == CMD_LO |=> !protection_selected)
		else $error("lockout did not hold the working path");

	a_reject_mode: assert property (@(posedge clk) disable iff (!reset_n)
		operator_command_valid && revert_select
			&& (cmd_in == CMD_FS0 || cmd_in == CMD_MS0 || cmd_in == CMD_EX0 || cmd_in == CMD_EX1)
			|=> command_rejected && ext_q == $past(ext_q))
		else $error("revertive mode took a non-revertive command");

	a_holdoff_zero: assert property (@(posedge clk) disable iff (!reset_n)
		holdoff_period == 7'h00 && new_bits != 4'h0 |=> (acc_q & $past(new_bits)) == $past(new_bits))
		else $error("condition delayed with zero hold-off");

	a_holdoff_wait: assert property (@(posedge clk) disable iff (!reset_n)
		holdoff_period != 7'h00 && ho_cnt_q < holdoff_period |=> (acc_q & ~$past(acc_q)) == 4'h0)
		else $error("condition taken before hold-off expired");

	a_wtr_hold: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_WTR && cond == REQ_NR && remote <= REQ_WTR && revert_select
			&& wtr_cnt_q < wtr_target |=> state_q == ST_WTR && protection_selected)
		else $error("left wait-to-restore early");

	a_switch_fast: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_WORK && sel_prot(winner) |=> protection_selected)
		else $error("switch to protection not taken at once");

	a_word_send: assert property (@(posedge clk) disable iff (!reset_n)
		ack2_q == tx_tog_q && 4'(req_local) != tx_word_q |=> tx_word_q == $past(4'(req_local)))
		else $error("local request not sent to far end");

endmodule // trail_prot

// *** verif/far_path_model.sv ***
// far side: transmit source and received working/protection streams
// assumes link_clk is the stream clock; fail levels come from the bench
`timescale 1ns/1ps
module far_path_model
	import trail_prot_pkg::*;
(
	input wire logic link_clk,
	input wire logic reset_n,
	input wire logic [3:0] far_word,
	output logic [7:0] normal_in_data,
	output logic normal_in_fs,
	output logic [7:0] working_in_data,
	output logic working_in_fs,
	output logic [7:0] protection_in_data,
	output logic protection_in_fs
);
	logic [3:0] cnt_q;
	logic [3:0] fr_q;
	// 16-byte frames keep persistency waits short
	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q <= 4'h0;
			fr_q <= 4'h0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'hF)
				fr_q <= fr_q + 4'h1;
		end
	end
	assign normal_in_fs = (cnt_q == 4'h0);
	assign working_in_fs = normal_in_fs;
	assign protection_in_fs = normal_in_fs;
	assign normal_in_data = {fr_q, cnt_q};
	assign working_in_data = {cnt_q, fr_q};
	// opaque word in the upper nibble of byte 4, protection only
	assign protection_in_data = (cnt_q == K3_BYTE_POS[3:0]) ? {far_word, fr_q} : ~{cnt_q, fr_q};
endmodule // far_path_model

// *** verif/vc4_bidir_trail_protection_tb_top.sv ***
// bench for trail_prot: commands, fail levels, stream monitor
// assumes STEP_CYCLES shrunk to 16 so wait-to-restore fits the run
`timescale 1ns/1ps
module vc4_bidir_trail_protection_tb_top;
	import trail_prot_pkg::*;
	logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
	logic revert_select = 1'b1, operator_command_valid = 1'b0, fail_report_enable = 1'b0;
	logic [3:0] wait_restore_period = 4'h1, operator_command = 4'h0, far_word = 4'h0;
	logic [6:0] holdoff_period = 7'h00;
	logic fail_w = 1'b0, deg_w = 1'b0, fail_p = 1'b0, deg_p = 1'b0;
	logic [7:0] n_d, w_d, p_d, wo_d, po_d, no_d;
	logic n_fs, w_fs, p_fs, wo_fs, po_fs, no_fs, tfa, fcr, psel, crej;
	logic [3:0] lreq;
	int fail_count = 0, checks_done = 0, cyc = 0;
	logic mon_on = 1'b0, chk_norm = 1'b0, word_on = 1'b0, exp_path = 1'b0;
	logic [3:0] word_val, pidx = 4'h0;
	logic [7:0] pn, pw, pp;
	logic [3:0] nr_c [4] = '{CMD_FS0, CMD_MS1, CMD_MS0, CMD_FS1};
	logic [3:0] nr_r [4] = '{REQ_FS0, REQ_MS1, REQ_MS0, REQ_FS1};
	logic nr_s [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	always #2 clk = ~clk;
	// 1 ns phase offset keeps link edges off every clk edge
	always
	begin
		if ($time == 0)
			#1;
		#32 link_clk = ~link_clk;
	end

	far_path_model far (.link_clk(link_clk), .reset_n(reset_n), .far_word(far_word),
		.normal_in_data(n_d), .normal_in_fs(n_fs), .working_in_data(w_d),
		.working_in_fs(w_fs), .protection_in_data(p_d), .protection_in_fs(p_fs));

	trail_prot #(.STEP_CYCLES(16)) uut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
		.revert_select(revert_select), .wait_restore_period(wait_restore_period),
		.holdoff_period(holdoff_period), .operator_command(operator_command),
		.operator_command_valid(operator_command_valid),
		.fail_report_enable(fail_report_enable), .normal_in_data(n_d), .normal_in_fs(n_fs),
		.working_out_data(wo_d), .working_out_fs(wo_fs), .protection_out_data(po_d),
		.protection_out_fs(po_fs), .working_in_data(w_d), .working_in_fs(w_fs),
		.trail_fail_indication_w(fail_w), .trail_degrade_indication_w(deg_w),
		.protection_in_data(p_d), .protection_in_fs(p_fs),
		.trail_fail_indication_p(fail_p), .trail_degrade_indication_p(deg_p),
		.normal_out_data(no_d), .normal_out_fs(no_fs), .trail_fail_action(tfa),
		.fail_cause_report(fcr), .protection_selected(psel), .local_request(lreq),
		.command_rejected(crej));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// operator command, then look at the refusal pulse one cycle on
	task automatic cmd(input logic [3:0] c, input logic rej);
		@(negedge clk);
		operator_command = c;
		operator_command_valid = 1'b1;
		@(negedge clk);
		chk({7'h0, crej}, {7'h0, rej});
		operator_command_valid = 1'b0;
		@(negedge clk);
	endtask

	// bounded wait for the selector, then let streams and word settle; F skips word
	task automatic go(input logic s, input logic [3:0] r, input int maxc);
		chk_norm = 1'b0;
		word_on = 1'b0;
		for (int i = 0; i < maxc && psel !== s; i++)
			@(negedge clk);
		chk({7'h0, psel}, {7'h0, s});
		repeat (40) @(posedge link_clk);
		@(negedge clk);
		exp_path = s;
		chk_norm = 1'b1;
		if (r !== 4'hF)
		begin
			chk({4'h0, lreq}, {4'h0, r});
			word_val = r;
			word_on = 1'b1;
		end
	endtask

	// stream monitor: each output against the byte seen one link cycle earlier
	always @(posedge link_clk)
	begin
		#1;
		if (mon_on)
		begin
			chk(wo_d, pn);
			chk({7'h0, wo_fs}, {7'h0, pidx == 4'h0});
			if (pidx == K3_BYTE_POS[3:0])
			begin
				chk({4'h0, po_d[3:0]}, {4'h0, pn[3:0]});
				if (word_on)
					chk({4'h0, po_d[7:4]}, {4'h0, word_val});
			end
			else
				chk(po_d, pn);
			if (chk_norm)
				chk(no_d, exp_path ? pp : pw);
		end
		pn = n_d;
		pw = w_d;
		pp = p_d;
		pidx = n_fs ? 4'h0 : pidx + 4'h1;
	end

	// hang guard, sized well above the longest wait-to-restore
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (2) @(negedge clk);
		repeat (2) @(posedge link_clk);
		@(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(posedge link_clk);
		mon_on = 1'b1;
		go(1'b0, REQ_NR, 50);
		revert_select = 1'b0;
		holdoff_period = 7'h05;
		wait_restore_period = 4'h9;
		repeat (20) @(posedge link_clk);
		revert_select = 1'b1;
		holdoff_period = 7'h00;
		wait_restore_period = 4'h1;
		repeat (20) @(posedge link_clk);
		chk({7'h0, psel}, 8'h00);
		foreach (nr_c[i])
			cmd(nr_c[i] == CMD_FS0 ? CMD_FS0 : (i == 1 ? CMD_EX0 : CMD_EX1), 1'b1);
		cmd(4'hF, 1'b1);
		cmd(CMD_LO, 1'b0);
		go(1'b0, REQ_LO, 50);
		fail_w = 1'b1;
		repeat (20) @(posedge link_clk);
		@(negedge clk);
		chk({7'h0, tfa}, 8'h01);
		chk({7'h0, fcr}, 8'h00);
		fail_report_enable = 1'b1;
		repeat (4) @(posedge link_clk);
		@(negedge clk);
		chk({7'h0, fcr}, 8'h01);
		cmd(CMD_CLR, 1'b0);
		go(1'b1, REQ_SFW, 50);
		chk({7'h0, tfa}, 8'h00);
		fail_w = 1'b0;
		go(1'b1, REQ_WTR, 50);
		repeat (8500) @(negedge clk);
		chk({7'h0, psel}, 8'h01);
		go(1'b0, REQ_NR, 1500);
		holdoff_period = 7'h02;
		fail_w = 1'b1;
		repeat (18) @(negedge clk);
		chk({7'h0, psel}, 8'h00);
		go(1'b1, REQ_SFW, 60);
		holdoff_period = 7'h00;
		revert_select = 1'b0;
		fail_w = 1'b0;
		go(1'b1, REQ_DNR, 50);
		deg_w = 1'b1;
		go(1'b1, REQ_SD, 50);
		deg_w = 1'b0;
		go(1'b1, REQ_DNR, 50);
		foreach (nr_c[i])
		begin
			cmd(nr_c[i], 1'b0);
			go(nr_s[i], nr_r[i], 50);
		end
		cmd(CMD_EX0, 1'b0);
		cmd(CMD_EX1, 1'b0);
		go(1'b1, REQ_EXER1, 50);
		cmd(4'hF, 1'b1);
		cmd(CMD_CLR, 1'b0);
		go(1'b1, REQ_DNR, 50);
		far_word = REQ_FS0;
		go(1'b0, 4'hF, 1500);
		wrap_up();
	end
endmodule // vc4_bidir_trail_protection_tb_top
